// File: hw/sdm_pkg.sv
package sdm_pkg;

    // ----------------------------------------
    // Register map and address shift
    // ----------------------------------------
    localparam logic [6:0] REG_RST_MUTE_RATE = 7'h10;
    localparam logic [6:0] REG_PS_FORMAT = 7'h11;
    localparam logic [6:0] REG_OP_FILTER = 7'h12;
    localparam logic [6:0] REG_PHASE = 7'h13;
    localparam logic [6:0] REG_SOFT_MUTE = 7'h14;
    localparam logic [6:0] REG_ZERO_STATUS = 7'h15;
    localparam logic [6:0] REG_ATT_FLAG_CFG = 7'h16;
    localparam logic [6:0] REG_RESERVED = 7'h17;
    localparam logic [6:0] REG_LEFT_ATT = 7'h18;
    localparam logic [6:0] REG_RIGHT_ATT = 7'h19;
    localparam logic [6:0] ADDR_SHIFT_UNIT = 7'h20;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_REG_DEFAULTS = 7;
    localparam int BIT_RESYNC = 6;
    localparam int AMUTE_LSB = 2;
    localparam int RATE_LSB = 0;
    localparam int BIT_PS_SELECT = 7;
    localparam int FORMAT_LSB = 0;
    localparam int BIT_OP_DISABLE = 4;
    localparam int BIT_FILTER = 0;
    localparam int BIT_STEP_MODE = 7;
    localparam int DEEMPH_LSB = 4;
    localparam int BIT_FLAG_FUNC = 3;
    localparam int BIT_FLAG_COMB = 1;
    localparam int BIT_FLAG_POL = 0;

    // ----------------------------------------
    // Levels and timing
    // ----------------------------------------
    localparam logic [7:0] ATT_NONE = 8'hFF;
    localparam logic [7:0] MUTE_FINE = 8'h80;
    localparam logic [7:0] MUTE_WIDE = 8'h9A;
    localparam int FS_PER_STEP = 8;
    localparam int RESYNC_CYCLES = 4;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        RATE_AUTO,
        RATE_SINGLE,
        RATE_DUAL,
        RATE_QUAD
    } sdm_rate_e;

    typedef enum logic [2:0] {
        RATIO_128,
        RATIO_192,
        RATIO_256,
        RATIO_384,
        RATIO_512,
        RATIO_768,
        RATIO_1152
    } sdm_ratio_e;

    typedef struct packed {
        logic [3:0] analog_mute_source_enables;
        sdm_rate_e sampling_rate_mode;
        logic power_save_select;
        logic [2:0] audio_format_select;
        logic operation_disable;
        logic filter_rolloff_select;
        logic [1:0] output_phase_invert;
        logic [1:0] channel_soft_mute;
        logic attenuation_step_mode;
        logic [1:0] deemphasis_rate_select;
        logic flag_pin_function_select;
        logic flag_channel_combination;
        logic flag_polarity_select;
        logic [7:0] left_level;
        logic [7:0] right_level;
    } sdm_cfg_s;

    localparam sdm_cfg_s CFG_DEFAULT = '{
        analog_mute_source_enables: 4'h0,
        sampling_rate_mode: RATE_AUTO,
        power_save_select: 1'b0,
        audio_format_select: 3'h0,
        operation_disable: 1'b0,
        filter_rolloff_select: 1'b0,
        output_phase_invert: 2'h0,
        channel_soft_mute: 2'h0,
        attenuation_step_mode: 1'b0,
        deemphasis_rate_select: 2'h0,
        flag_pin_function_select: 1'b0,
        flag_channel_combination: 1'b0,
        flag_polarity_select: 1'b0,
        left_level: ATT_NONE,
        right_level: ATT_NONE
    };

    typedef struct packed {
        logic power_down;
        logic force_common_mode;
        logic force_analog_ground;
        logic dac_disconnect;
        logic analog_mute;
    } sdm_out_s;

endpackage : sdm_pkg

// File: hw/sdm_att_ramp.sv
`timescale 1ns/1ps

module sdm_att_ramp
    import sdm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_step,
    input wire logic [7:0] i_target,
    input wire logic i_mute,
    input wire logic i_wide,
    output logic [7:0] o_level,
    output logic o_muted
);

    logic [7:0] goal;

    // ----------------------------------------
    // Ramp toward goal, one code per step
    // ----------------------------------------
    // Mute wins over the programmed level
    assign goal = i_mute ? (i_wide ? MUTE_WIDE : MUTE_FINE) : i_target;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_level <= ATT_NONE;
        end else if (i_step && o_level < goal) begin
            o_level <= o_level + 8'h01;
        end else if (i_step && o_level > goal) begin
            o_level <= o_level - 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_muted <= 1'b0;
        end else begin
            o_muted <= i_mute && (o_level <= (i_wide ? MUTE_WIDE : MUTE_FINE));
        end
    end

    ramp_one_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !$past(i_step) |-> o_level == $past(o_level))
        else $error("level moved without a step");

endmodule : sdm_att_ramp

// File: hw/sdm_rate_resolve.sv
`timescale 1ns/1ps

module sdm_rate_resolve
    import sdm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire sdm_rate_e i_mode,
    input wire sdm_ratio_e i_ratio,
    output sdm_rate_e o_rate
);

    // ----------------------------------------
    // Automatic rate from clock ratio
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rate <= RATE_SINGLE;
        end else if (i_mode != RATE_AUTO) begin
            o_rate <= i_mode;
        end else begin
            case (i_ratio)
                RATIO_128, RATIO_192: o_rate <= RATE_QUAD;
                RATIO_256, RATIO_384: o_rate <= RATE_DUAL;
                default: o_rate <= RATE_SINGLE;
            endcase
        end
    end

    auto_quad_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_mode == RATE_AUTO && i_ratio == RATIO_128) |=> o_rate == RATE_QUAD)
        else $error("auto rate not quad at 128 fs");

endmodule : sdm_rate_resolve

// File: hw/sdm_mode_regs.sv
`timescale 1ns/1ps

module sdm_mode_regs
    import sdm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_address_select_high,
    input wire logic i_address_select_low,
    input wire logic i_fs_tick,
    input wire sdm_ratio_e i_ratio,
    input wire logic [1:0] i_zero_detect,
    input wire logic i_clock_halt,
    input wire logic i_async_detect,
    output logic o_ack,
    output logic [7:0] o_rdata,
    output sdm_cfg_s o_cfg,
    output sdm_rate_e o_rate,
    output sdm_out_s o_out,
    output logic o_defaults_pulse,
    output logic o_resync,
    output logic o_clear_dac_data,
    output logic [7:0] o_left_att,
    output logic [7:0] o_right_att,
    output logic [1:0] o_muted
);

    // ----------------------------------------
    // Pin synchronisers and address decode
    // ----------------------------------------
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic [6:0] base;
    logic [6:0] local_addr;
    logic mapped;
    logic wr_hit;
    logic [7:0] rd_value;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_meta <= 2'h0;
            sel_sync <= 2'h0;
        end else begin
            sel_meta <= {i_address_select_high, i_address_select_low};
            sel_sync <= sel_meta;
        end
    end

    // Shift of 0, 32, 64 or 96 from the two select pins
    assign base = ADDR_SHIFT_UNIT * {5'h00, sel_sync};
    assign local_addr = i_addr - base;
    assign mapped = i_addr >= base && local_addr >= REG_RST_MUTE_RATE
        && local_addr <= REG_RIGHT_ATT;
    // Accepted regardless of the disable state
    assign wr_hit = i_req && i_wr && mapped;

    // ----------------------------------------
    // Self-clearing triggers
    // ----------------------------------------
    logic defaults_req;
    logic resync_req;
    logic [2:0] resync_cnt;

    assign defaults_req = wr_hit && local_addr == REG_RST_MUTE_RATE
        && !i_wdata[BIT_REG_DEFAULTS];
    assign resync_req = wr_hit && local_addr == REG_RST_MUTE_RATE
        && !i_wdata[BIT_RESYNC];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_defaults_pulse <= 1'b0;
        end else begin
            o_defaults_pulse <= defaults_req;
        end
    end

    // Resync holds for a fixed count so downstream dividers can realign
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            resync_cnt <= 3'h0;
        end else if (resync_req) begin
            resync_cnt <= 3'(RESYNC_CYCLES);
        end else if (resync_cnt != 3'h0) begin
            resync_cnt <= resync_cnt - 3'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_resync <= 1'b0;
        end else begin
            o_resync <= resync_req || resync_cnt > 3'h1;
        end
    end

    // ----------------------------------------
    // Configuration store
    // ----------------------------------------
    // Reserved bits are dropped on write, so a careless host cannot set them
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || defaults_req) begin
            o_cfg <= CFG_DEFAULT;
        end else if (wr_hit) begin
            case (local_addr)
                REG_RST_MUTE_RATE: begin
                    o_cfg.analog_mute_source_enables <= i_wdata[AMUTE_LSB +: 4];
                    o_cfg.sampling_rate_mode <= sdm_rate_e'(i_wdata[RATE_LSB +: 2]);
                end
                REG_PS_FORMAT: begin
                    o_cfg.power_save_select <= i_wdata[BIT_PS_SELECT];
                    o_cfg.audio_format_select <= i_wdata[FORMAT_LSB +: 3];
                end
                REG_OP_FILTER: begin
                    o_cfg.operation_disable <= i_wdata[BIT_OP_DISABLE];
                    o_cfg.filter_rolloff_select <= i_wdata[BIT_FILTER];
                end
                REG_PHASE: begin
                    o_cfg.output_phase_invert <= i_wdata[1:0];
                end
                REG_SOFT_MUTE: begin
                    o_cfg.channel_soft_mute <= i_wdata[1:0];
                end
                REG_ATT_FLAG_CFG: begin
                    o_cfg.attenuation_step_mode <= i_wdata[BIT_STEP_MODE];
                    o_cfg.deemphasis_rate_select <= i_wdata[DEEMPH_LSB +: 2];
                    o_cfg.flag_pin_function_select <= i_wdata[BIT_FLAG_FUNC];
                    o_cfg.flag_channel_combination <= i_wdata[BIT_FLAG_COMB];
                    o_cfg.flag_polarity_select <= i_wdata[BIT_FLAG_POL];
                end
                REG_LEFT_ATT: begin
                    o_cfg.left_level <= i_wdata;
                end
                REG_RIGHT_ATT: begin
                    o_cfg.right_level <= i_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rd_value = 8'h00;
        case (local_addr)
            REG_RST_MUTE_RATE: begin
                rd_value[BIT_REG_DEFAULTS] = 1'b1;
                rd_value[BIT_RESYNC] = resync_cnt == 3'h0;
                rd_value[AMUTE_LSB +: 4] = o_cfg.analog_mute_source_enables;
                rd_value[RATE_LSB +: 2] = o_cfg.sampling_rate_mode;
            end
            REG_PS_FORMAT: begin
                rd_value[BIT_PS_SELECT] = o_cfg.power_save_select;
                rd_value[FORMAT_LSB +: 3] = o_cfg.audio_format_select;
            end
            REG_OP_FILTER: begin
                rd_value[BIT_OP_DISABLE] = o_cfg.operation_disable;
                rd_value[BIT_FILTER] = o_cfg.filter_rolloff_select;
            end
            REG_PHASE: rd_value[1:0] = o_cfg.output_phase_invert;
            REG_SOFT_MUTE: rd_value[1:0] = o_cfg.channel_soft_mute;
            REG_ZERO_STATUS: rd_value[1:0] = i_zero_detect;
            REG_ATT_FLAG_CFG: begin
                rd_value[BIT_STEP_MODE] = o_cfg.attenuation_step_mode;
                rd_value[DEEMPH_LSB +: 2] = o_cfg.deemphasis_rate_select;
                rd_value[BIT_FLAG_FUNC] = o_cfg.flag_pin_function_select;
                rd_value[BIT_FLAG_COMB] = o_cfg.flag_channel_combination;
                rd_value[BIT_FLAG_POL] = o_cfg.flag_polarity_select;
            end
            REG_LEFT_ATT: rd_value = o_cfg.left_level;
            REG_RIGHT_ATT: rd_value = o_cfg.right_level;
            default: rd_value = 8'h00;
        endcase
    end

    // Unmapped addresses get no acknowledge, as the serial port expects
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_ack <= i_req && mapped;
            o_rdata <= (i_req && !i_wr && mapped) ? rd_value : 8'h00;
        end
    end

    // ----------------------------------------
    // Operation and analog mute outputs
    // ----------------------------------------
    logic op_dis;

    assign op_dis = o_cfg.operation_disable;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_out <= '0;
            o_clear_dac_data <= 1'b0;
        end else begin
            o_out.dac_disconnect <= op_dis;
            o_clear_dac_data <= op_dis || o_resync;
            o_out.force_common_mode <= op_dis && o_cfg.power_save_select;
            o_out.force_analog_ground <= op_dis && !o_cfg.power_save_select;
            o_out.power_down <= op_dis && !o_cfg.power_save_select;
            o_out.analog_mute <=
                (o_cfg.analog_mute_source_enables[0] && i_clock_halt)
                || (o_cfg.analog_mute_source_enables[1] && i_async_detect)
                || (o_cfg.analog_mute_source_enables[2] && &i_zero_detect)
                || (o_cfg.analog_mute_source_enables[3] && op_dis);
        end
    end

    // ----------------------------------------
    // Attenuation step divider and ramps
    // ----------------------------------------
    logic [2:0] fs_cnt;
    logic att_step;

    // Resync restarts the sample count along with the rest of the datapath
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || o_resync) begin
            fs_cnt <= 3'h0;
            att_step <= 1'b0;
        end else begin
            att_step <= i_fs_tick && fs_cnt == 3'(FS_PER_STEP - 1);
            if (i_fs_tick) begin
                fs_cnt <= fs_cnt + 3'h1;
            end
        end
    end

    sdm_att_ramp u_left_ramp (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_step(att_step),
        .i_target(o_cfg.left_level),
        .i_mute(o_cfg.channel_soft_mute[0]),
        .i_wide(o_cfg.attenuation_step_mode),
        .o_level(o_left_att),
        .o_muted(o_muted[0])
    );

    sdm_att_ramp u_right_ramp (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_step(att_step),
        .i_target(o_cfg.right_level),
        .i_mute(o_cfg.channel_soft_mute[1]),
        .i_wide(o_cfg.attenuation_step_mode),
        .o_level(o_right_att),
        .o_muted(o_muted[1])
    );

    sdm_rate_resolve u_rate (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_mode(o_cfg.sampling_rate_mode),
        .i_ratio(i_ratio),
        .o_rate(o_rate)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    defaults_restore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        defaults_req |=> o_cfg == CFG_DEFAULT && o_defaults_pulse)
        else $error("defaults write did not restore registers");

    resync_keeps_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (resync_req && !defaults_req) |=> o_resync [*3] ##1 (o_resync && resync_cnt == 3'h1))
        else $error("resync length wrong");

    resync_readback_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        resync_req |=> ##[1:5] resync_cnt == 3'h0)
        else $error("resync bit never read back as one");

    analog_mute_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_cfg.analog_mute_source_enables == 4'h0 && !defaults_req) |=> !o_out.analog_mute)
        else $error("analog mute with all sources off");

    power_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (op_dis && !o_cfg.power_save_select) |=> o_out.power_down && !o_out.force_common_mode)
        else $error("disable without power down");

    common_mode_voltage_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (op_dis && o_cfg.power_save_select) |=> o_out.force_common_mode && !o_out.power_down)
        else $error("disable did not force common mode");

    disconnect_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        op_dis |=> o_out.dac_disconnect && o_clear_dac_data)
        else $error("disable did not cut input");

    unmapped_nack_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !mapped) |=> !o_ack)
        else $error("unmapped address acknowledged");

    step_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        att_step |=> !att_step)
        else $error("attenuation step longer than one cycle");

endmodule : sdm_mode_regs

// File: tb/sdm_host_model.sv
`timescale 1ns/1ps

module sdm_host_model (
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    output logic o_req,
    output logic o_wr,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata
);

    // ----------------------------------------
    // Idle state
    // ----------------------------------------
    initial begin
        o_req = 1'b0;
        o_wr = 1'b0;
        o_addr = 7'h00;
        o_wdata = 8'h00;
    end

    // ----------------------------------------
    // One register access
    // ----------------------------------------
    // Caller keeps reserved bits zero, uses shifted address
    task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                          output logic ack, output logic [7:0] rdata);
        @(posedge i_clk);
        o_req <= 1'b1;
        o_wr <= wr;
        o_addr <= addr;
        o_wdata <= wdata;
        @(posedge i_clk);
        // Released lines flip so a stale value never looks valid
        o_req <= 1'b0;
        o_wr <= ~wr;
        o_addr <= ~addr;
        o_wdata <= ~wdata;
        @(posedge i_clk);
        ack = i_ack;
        rdata = i_rdata;
    endtask : access

endmodule : sdm_host_model

// File: tb/testbench.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module testbench
    import sdm_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0, fs_tick = 1'b0;
    logic clock_halt = 1'b0, async_det = 1'b0, req, wr_en, ack, k;
    logic [1:0] zero_det = 2'b00, muted;
    sdm_ratio_e ratio = RATIO_512;
    logic [6:0] addr, shift = 7'h00;
    logic [7:0] wdata, rdata, d, left_att, right_att;
    sdm_cfg_s cfg;
    sdm_rate_e rate;
    sdm_out_s out;
    logic defaults_pulse, resync, clear_dac;
    int n_errors = 0, compares = 0, cycles = 0;

    sdm_mode_regs sdm_mode_regs_inst (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
        .i_wr(wr_en), .i_addr(addr), .i_wdata(wdata), .i_address_select_high(sel_hi),
        .i_address_select_low(sel_lo), .i_fs_tick(fs_tick), .i_ratio(ratio),
        .i_zero_detect(zero_det), .i_clock_halt(clock_halt), .i_async_detect(async_det),
        .o_ack(ack), .o_rdata(rdata), .o_cfg(cfg), .o_rate(rate), .o_out(out),
        .o_defaults_pulse(defaults_pulse), .o_resync(resync), .o_clear_dac_data(clear_dac),
        .o_left_att(left_att), .o_right_att(right_att), .o_muted(muted));

    sdm_host_model sdm_host_model_inst (.i_clk(clk), .i_ack(ack), .i_rdata(rdata),
        .o_req(req), .o_wr(wr_en), .o_addr(addr), .o_wdata(wdata));

    // ----------------------------------------
    // Clock, timeout, verdict
    // ----------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end

    // Ramp tests dominate; about 6000 cycles expected
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            fs_tick <= 1'b1;
            @(posedge clk);
            fs_tick <= 1'b0;
        end
    endtask : tick

    task automatic wr(input logic [6:0] ra, input logic [7:0] v);
        sdm_host_model_inst.access(1'b1, ra + shift, v, k, d);
        `CHK(k, 1'b1)
    endtask : wr

    task automatic rd(input logic [6:0] ra);
        sdm_host_model_inst.access(1'b0, ra + shift, 8'h00, k, d);
        `CHK(k, 1'b1)
    endtask : rd

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_ramp();
        int i;
        `CHK(cfg, CFG_DEFAULT)
        wr(REG_LEFT_ATT, 8'hFD);
        tick(8);
        cyc(3);
        `CHK(left_att, 8'hFE)
        tick(8);
        cyc(3);
        `CHK(left_att, 8'hFD)
        `CHK(right_att, 8'hFF)
        wr(REG_SOFT_MUTE, 8'h01);
        for (i = 0; i < 1100 && muted[0] !== 1'b1; i++) tick(1);
        `CHK(left_att, MUTE_FINE)
        `CHK(muted, 2'b01)
        wr(REG_SOFT_MUTE, 8'h00);
        tick(1008);
        cyc(3);
        `CHK(left_att, 8'hFD)
    endtask : test_ramp

    task automatic test_status();
        int i;
        rd(REG_RST_MUTE_RATE);
        `CHK(d, 8'hC0)
        rd(REG_ATT_FLAG_CFG);
        `CHK(d, 8'h00)
        zero_det <= 2'b10;
        wr(REG_ZERO_STATUS, 8'h01);
        rd(REG_ZERO_STATUS);
        `CHK(d, 8'h02)
        rd(REG_RESERVED);
        `CHK(d, 8'h00)
        // Wide step mode moves the mute floor
        wr(REG_ATT_FLAG_CFG, 8'hBB);
        rd(REG_ATT_FLAG_CFG);
        `CHK(d, 8'hBB)
        wr(REG_SOFT_MUTE, 8'h01);
        for (i = 0; i < 1100 && muted[0] !== 1'b1; i++) tick(1);
        `CHK(left_att, MUTE_WIDE)
        `CHK(muted, 2'b01)
        wr(REG_SOFT_MUTE, 8'h00);
        wr(REG_ATT_FLAG_CFG, 8'h00);
    endtask : test_status

    task automatic test_fields();
        for (int f = 0; f < 8; f++) begin
            wr(REG_PS_FORMAT, 8'(f));
            `CHK(cfg.audio_format_select, 3'(f))
        end
        for (int m = 0; m < 4; m++) begin
            wr(REG_RST_MUTE_RATE, 8'hC0 | 8'(m));
            `CHK(cfg.sampling_rate_mode, 2'(m))
            cyc(2);
            `CHK(rate, (m == 0) ? RATE_SINGLE : sdm_rate_e'(m))
        end
        for (int b = 0; b < 4; b++) begin
            wr(REG_RST_MUTE_RATE, 8'hC0 | 8'(1 << (b + 2)));
            `CHK(cfg.analog_mute_source_enables, 4'(1 << b))
        end
        wr(REG_RST_MUTE_RATE, 8'hC4);
        clock_halt <= 1'b1;
        cyc(3);
        `CHK(out.analog_mute, 1'b1)
        clock_halt <= 1'b0;
        async_det <= 1'b1;
        cyc(3);
        `CHK(out.analog_mute, 1'b0)
        async_det <= 1'b0;
    endtask : test_fields

    task automatic test_disable();
        logic p;
        wr(REG_RST_MUTE_RATE, 8'hE0);
        for (int ps = 0; ps < 2; ps++) begin
            p = 1'(ps);
            wr(REG_PS_FORMAT, {p, 7'h00});
            wr(REG_OP_FILTER, 8'h10);
            cyc(2);
            `CHK(out.power_down, ~p)
            `CHK(out.force_common_mode, p)
            `CHK(out.force_analog_ground, ~p)
            `CHK(out.dac_disconnect, 1'b1)
            `CHK(clear_dac, 1'b1)
            `CHK(out.analog_mute, 1'b1)
            rd(REG_PS_FORMAT);
            `CHK(d, {p, 7'h00})
            wr(REG_OP_FILTER, 8'h00);
            cyc(2);
            `CHK(out.dac_disconnect, 1'b0)
        end
    endtask : test_disable

    task automatic test_resets();
        wr(REG_PS_FORMAT, 8'h85);
        wr(REG_RST_MUTE_RATE, 8'h7F);
        `CHK(defaults_pulse, 1'b1)
        `CHK(cfg, CFG_DEFAULT)
        rd(REG_RST_MUTE_RATE);
        `CHK(d, 8'hC0)
        wr(REG_RST_MUTE_RATE, 8'h81);
        `CHK(resync, 1'b1)
        rd(REG_RST_MUTE_RATE);
        `CHK(d, 8'h81)
        cyc(4);
        rd(REG_RST_MUTE_RATE);
        `CHK(d, 8'hC1)
        `CHK(resync, 1'b0)
        `CHK(cfg.sampling_rate_mode, RATE_SINGLE)
    endtask : test_resets

    task automatic test_auto_rate();
        sdm_rate_e e;
        wr(REG_RST_MUTE_RATE, 8'hC0);
        for (int r = 0; r < 7; r++) begin
            ratio <= sdm_ratio_e'(r);
            e = (r < 2) ? RATE_QUAD : (r < 4) ? RATE_DUAL : RATE_SINGLE;
            cyc(3);
            `CHK(rate, e)
        end
    endtask : test_auto_rate

    task automatic test_shift();
        for (int p = 0; p < 4; p++) begin
            sel_hi <= p[1];
            sel_lo <= p[0];
            shift = 7'(32 * p);
            cyc(3);
            rd(REG_SOFT_MUTE);
            `CHK(d, 8'h00)
            sdm_host_model_inst.access(1'b0, REG_SOFT_MUTE, 8'h00, k, d);
            `CHK(k, p == 0)
        end
    endtask : test_shift

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(6);
        rst_n <= 1'b1;
        cyc(3);
        test_ramp();
        test_status();
        test_fields();
        test_disable();
        test_resets();
        test_auto_rate();
        test_shift();
        give_verdict();
    end

endmodule : testbench
